// ===== pts_pkg.sv
// Purpose: Shared types and constants of the pacing test sequencer
// Assumes: 100 MHz hclk, AHB-Lite word registers
// Notes: Settings are indices into a fixed ordered table, low to high
package pts_pkg;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_TEMP = 3'h1,
    ST_THRESH = 3'h2,
    ST_PR = 3'h3,
    ST_IMP = 3'h4
  } seq_state_e;

  typedef enum logic [3:0] {
    CMD_NONE = 4'h0,
    CMD_INTERROGATE = 4'h1,
    CMD_TEMP_START = 4'h2,
    CMD_TEMP_STOP = 4'h3,
    CMD_EMERGENCY = 4'h4,
    CMD_THERAPY_ABORT = 4'h5,
    CMD_THR_START = 4'h6,
    CMD_THR_END = 4'h7,
    CMD_PR_MEASURE = 4'h8,
    CMD_IMP_MEASURE = 4'h9
  } cmd_e;

  typedef struct packed {
    logic [4:0] amp_a;
    logic [4:0] amp_v;
    logic [4:0] pw_a;
    logic [4:0] pw_v;
  } pace_set_s;

  // Byte addresses
  localparam logic [7:0] ADDR_CMD = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_TEMP = 8'h08;
  localparam logic [7:0] ADDR_THR_CFG = 8'h0C;
  localparam logic [7:0] ADDR_PERM = 8'h10;
  localparam logic [7:0] ADDR_THR_RES = 8'h14;
  localparam logic [7:0] ADDR_PR_RES = 8'h18;
  localparam logic [7:0] ADDR_IMP_RES = 8'h1C;

  // Settings fields, same layout in TEMP and PERM
  localparam int FLD_AMP_A = 0;
  localparam int FLD_AMP_V = 8;
  localparam int FLD_PW_A = 16;
  localparam int FLD_PW_V = 24;
  localparam int THR_QTY_BIT = 0;
  localparam int THR_CH_BIT = 1;
  localparam int THR_START_LSB = 8;
  localparam int RES_VAL_LSB = 0;
  localparam int RES_LE_BIT = 8;
  localparam int RES_QTY_BIT = 9;
  localparam int RES_CH_BIT = 10;
  localparam int RES_VALID_BIT = 15;
  localparam int PR_R_LSB = 8;
  localparam int STS_STATE_LSB = 0;
  localparam int STS_BUSY_BIT = 4;
  localparam int STS_REJECT_BIT = 5;
  localparam int STS_TACHY_BIT = 6;
  localparam int STS_LINK_BIT = 7;

  // Setting table order
  localparam logic [4:0] AMP_OFF_IDX = 5'h00;
  localparam logic [4:0] AMP_MIN_IDX = 5'h01;
  localparam logic [4:0] AMP_MAX_IDX = 5'h1F;
  localparam logic [4:0] PW_MIN_IDX = 5'h00;
  localparam logic [4:0] PW_MAX_IDX = 5'h1F;
  localparam logic [4:0] AMP_5V0_IDX = 5'h14;
  localparam logic [4:0] PW_0M5_IDX = 5'h05;
  localparam logic [4:0] THR_BACKOFF = 5'h03;
  localparam logic [1:0] THR_LAST_CYCLE = 2'h3;

  localparam pace_set_s NOMINAL_SET = '{5'h0C, 5'h0C, 5'h05, 5'h05};
  localparam logic [4:0] THR_START_RST = 5'h0C;

  localparam int LINK_LOSS_MS = 250;
  localparam int CLK_KHZ = 100000;
  localparam int LINK_LOSS_CYCLES = LINK_LOSS_MS * CLK_KHZ;

endpackage : pts_pkg

// ===== link_monitor.sv
// Purpose: Synchronise the telemetry link presence and time its absence
// Assumes: link_present_pin is asynchronous to hclk
// Notes: link_lost rises once absence exceeds LOSS_CYCLES
`timescale 1ns/10ps
module link_monitor #(
  parameter int LOSS_CYCLES = pts_pkg::LINK_LOSS_CYCLES
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic link_present_pin,
  output logic link_up,
  output logic link_lost
);

  logic s1_q, s2_q, s3_q;
  logic [31:0] cnt_q;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
    end else begin
      s1_q <= link_present_pin;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // Level only taken when the last two stages agree
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      link_up <= 1'b0;
    end else if (s2_q == s3_q) begin
      link_up <= s3_q;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_q <= 32'h0;
      link_lost <= 1'b0;
    end else if (link_up) begin
      cnt_q <= 32'h0;
      link_lost <= 1'b0;
    end else if (cnt_q < 32'(LOSS_CYCLES)) begin
      cnt_q <= cnt_q + 32'h1;
    end else begin
      link_lost <= 1'b1;
    end
  end

endmodule : link_monitor

// ===== pacing_test_sequencer.sv
// Purpose: Temporary pacing, threshold, P/R-wave and impedance sequencing
// Assumes: AHB-Lite slave, single word transfers, zero wait states
// Notes: Settings are table indices; the pacing engine turns them into
//        pulses. Test results persist across sessions until overwritten.
`timescale 1ns/10ps
module pacing_test_sequencer #(
  parameter int LINK_LOSS_CYCLES = pts_pkg::LINK_LOSS_CYCLES
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic link_present,
  input wire logic tachy_episode,
  input wire logic cycle_event,
  input wire logic pr_done,
  input wire logic [7:0] p_amp,
  input wire logic [7:0] r_lv_amp,
  input wire logic [7:0] r_rv_amp,
  input wire logic imp_done,
  input wire logic [15:0] imp_value,
  output pts_pkg::pace_set_s pace_set,
  output logic pace_enable,
  output logic backup_vvi_en,
  output logic triggered_mode,
  output logic v_leads_joint,
  output logic temp_active,
  output logic busy_refusal_indication,
  output logic emergency_req,
  output logic therapy_abort_req
);

  pts_pkg::seq_state_e state_q;
  pts_pkg::pace_set_s temp_q, perm_q, pace_d;
  logic [7:0] addr_q;
  logic wr_q;
  logic thr_qty_q, thr_ch_q;
  logic [4:0] thr_start_q, thr_val_q;
  logic [1:0] thr_cnt_q;
  logic [15:0] thr_res_q;
  logic [16:0] pr_res_q;
  logic [15:0] imp_res_q;
  logic reject_q;
  logic t1_q, t2_q, t3_q, tachy_q;
  logic link_up, link_lost;
  logic cmd_wr, sts_wr, busy_set, reject_set, go_idle;
  pts_pkg::cmd_e cmd;
  logic [4:0] thr_min, thr_max, thr_up, thr_def;
  logic [5:0] thr_sum;

  link_monitor #(.LOSS_CYCLES(LINK_LOSS_CYCLES)) u_link (
    .hclk(hclk),
    .hresetn(hresetn),
    .link_present_pin(link_present),
    .link_up(link_up),
    .link_lost(link_lost)
  );

  // Tachy flag from the detector pin
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      t1_q <= 1'b0;
      t2_q <= 1'b0;
      t3_q <= 1'b0;
      tachy_q <= 1'b0;
    end else begin
      t1_q <= tachy_episode;
      t2_q <= t1_q;
      t3_q <= t2_q;
      if (t2_q == t3_q) begin
        tachy_q <= t3_q;
      end
    end
  end

  // AHB-Lite: address phase captured, write done in the data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_q <= 1'b0;
      addr_q <= 8'h00;
      hrdata <= 32'h0;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      wr_q <= hsel && htrans[1] && hready && hwrite;
      if (hsel && htrans[1] && hready) begin
        addr_q <= haddr[7:0];
        if (!hwrite) begin
          hrdata <= rd_mux(haddr[7:0]);
        end
      end
    end
  end

  function automatic logic [31:0] set_word(input pts_pkg::pace_set_s s);
    logic [31:0] w;
    w = 32'h0;
    w[pts_pkg::FLD_AMP_A +: 5] = s.amp_a;
    w[pts_pkg::FLD_AMP_V +: 5] = s.amp_v;
    w[pts_pkg::FLD_PW_A +: 5] = s.pw_a;
    w[pts_pkg::FLD_PW_V +: 5] = s.pw_v;
    return w;
  endfunction : set_word

  function automatic logic [31:0] rd_mux(input logic [7:0] a);
    logic [31:0] w;
    w = 32'h0;
    case (a)
      pts_pkg::ADDR_STATUS: begin
        w[pts_pkg::STS_STATE_LSB +: 3] = state_q;
        w[pts_pkg::STS_BUSY_BIT] = busy_refusal_indication;
        w[pts_pkg::STS_REJECT_BIT] = reject_q;
        w[pts_pkg::STS_TACHY_BIT] = tachy_q;
        w[pts_pkg::STS_LINK_BIT] = link_up;
      end
      pts_pkg::ADDR_TEMP: w = set_word(temp_q);
      pts_pkg::ADDR_PERM: w = set_word(perm_q);
      pts_pkg::ADDR_THR_CFG: begin
        w[pts_pkg::THR_QTY_BIT] = thr_qty_q;
        w[pts_pkg::THR_CH_BIT] = thr_ch_q;
        w[pts_pkg::THR_START_LSB +: 5] = thr_start_q;
      end
      pts_pkg::ADDR_THR_RES: w[15:0] = thr_res_q;
      pts_pkg::ADDR_PR_RES: w[16:0] = pr_res_q;
      pts_pkg::ADDR_IMP_RES: w[15:0] = imp_res_q;
      default: w = 32'h0;
    endcase
    return w;
  endfunction : rd_mux

  function automatic pts_pkg::pace_set_s word_set(input logic [31:0] w);
    pts_pkg::pace_set_s s;
    s.amp_a = w[pts_pkg::FLD_AMP_A +: 5];
    s.amp_v = w[pts_pkg::FLD_AMP_V +: 5];
    s.pw_a = w[pts_pkg::FLD_PW_A +: 5];
    s.pw_v = w[pts_pkg::FLD_PW_V +: 5];
    return s;
  endfunction : word_set

  // Command decode and acceptance
  always_comb begin
    cmd_wr = wr_q && (addr_q == pts_pkg::ADDR_CMD);
    sts_wr = wr_q && (addr_q == pts_pkg::ADDR_STATUS);
    cmd = pts_pkg::cmd_e'(hwdata[3:0]);
    busy_set = 1'b0;
    reject_set = 1'b0;
    if (cmd_wr && cmd != pts_pkg::CMD_NONE) begin
      if (state_q == pts_pkg::ST_TEMP) begin
        reject_set = !(cmd == pts_pkg::CMD_TEMP_STOP ||
          cmd == pts_pkg::CMD_EMERGENCY ||
          cmd == pts_pkg::CMD_THERAPY_ABORT);
      end else if (state_q == pts_pkg::ST_IDLE) begin
        busy_set = tachy_q && (cmd == pts_pkg::CMD_TEMP_START ||
          cmd == pts_pkg::CMD_THR_START ||
          cmd == pts_pkg::CMD_IMP_MEASURE);
      end
    end
    go_idle = cmd_wr && (cmd == pts_pkg::CMD_EMERGENCY ||
      cmd == pts_pkg::CMD_THERAPY_ABORT);
  end

  // Threshold table arithmetic
  always_comb begin
    thr_min = thr_qty_q ? pts_pkg::PW_MIN_IDX : pts_pkg::AMP_MIN_IDX;
    thr_max = thr_qty_q ? pts_pkg::PW_MAX_IDX : pts_pkg::AMP_MAX_IDX;
    thr_up = (thr_val_q >= thr_max) ? thr_max : thr_val_q + 5'h01;
    thr_sum = {1'b0, thr_res_q[pts_pkg::RES_VAL_LSB +: 5]} +
      {1'b0, pts_pkg::THR_BACKOFF};
    thr_def = (thr_sum > {1'b0, thr_max}) ? thr_max : thr_sum[4:0];
  end

  // Sticky refusal flags, write one to clear; a new refusal wins
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      busy_refusal_indication <= 1'b0;
      reject_q <= 1'b0;
    end else begin
      if (busy_set) begin
        busy_refusal_indication <= 1'b1;
      end else if (sts_wr && hwdata[pts_pkg::STS_BUSY_BIT]) begin
        busy_refusal_indication <= 1'b0;
      end
      if (reject_set) begin
        reject_q <= 1'b1;
      end else if (sts_wr && hwdata[pts_pkg::STS_REJECT_BIT]) begin
        reject_q <= 1'b0;
      end
    end
  end

  // Software settings; interrogation reloads the temporary set
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      temp_q <= pts_pkg::NOMINAL_SET;
      perm_q <= pts_pkg::NOMINAL_SET;
      thr_qty_q <= 1'b0;
      thr_ch_q <= 1'b0;
      thr_start_q <= pts_pkg::THR_START_RST;
    end else if (cmd_wr && cmd == pts_pkg::CMD_INTERROGATE &&
        state_q != pts_pkg::ST_TEMP) begin
      temp_q <= pts_pkg::NOMINAL_SET;
      if (thr_res_q[pts_pkg::RES_VALID_BIT]) begin
        thr_start_q <= thr_def;
      end
    end else if (wr_q && state_q == pts_pkg::ST_IDLE) begin
      case (addr_q)
        pts_pkg::ADDR_TEMP: temp_q <= word_set(hwdata);
        pts_pkg::ADDR_PERM: perm_q <= word_set(hwdata);
        pts_pkg::ADDR_THR_CFG: begin
          thr_qty_q <= hwdata[pts_pkg::THR_QTY_BIT];
          thr_ch_q <= hwdata[pts_pkg::THR_CH_BIT];
          thr_start_q <= hwdata[pts_pkg::THR_START_LSB +: 5];
        end
        default: ;
      endcase
    end
  end

  // Test sequencing and result storage
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_q <= pts_pkg::ST_IDLE;
      thr_val_q <= 5'h00;
      thr_cnt_q <= 2'h0;
      thr_res_q <= 16'h0;
      pr_res_q <= 17'h0;
      imp_res_q <= 16'h0;
    end else begin
      case (state_q)
        pts_pkg::ST_IDLE: begin
          if (cmd_wr && !busy_set) begin
            case (cmd)
              pts_pkg::CMD_TEMP_START: begin
                if (link_up) begin
                  state_q <= pts_pkg::ST_TEMP;
                end
              end
              pts_pkg::CMD_THR_START: begin
                if (link_up) begin
                  state_q <= pts_pkg::ST_THRESH;
                  thr_val_q <= (thr_start_q > thr_max) ? thr_max :
                    (thr_start_q < thr_min) ? thr_min : thr_start_q;
                  thr_cnt_q <= 2'h0;
                end
              end
              pts_pkg::CMD_PR_MEASURE: state_q <= pts_pkg::ST_PR;
              pts_pkg::CMD_IMP_MEASURE: state_q <= pts_pkg::ST_IMP;
              default: ;
            endcase
          end
        end
        pts_pkg::ST_TEMP: begin
          if (link_lost || go_idle ||
              (cmd_wr && cmd == pts_pkg::CMD_TEMP_STOP)) begin
            state_q <= pts_pkg::ST_IDLE;
          end
        end
        pts_pkg::ST_THRESH: begin
          if (link_lost || go_idle ||
              (cmd_wr && cmd == pts_pkg::CMD_THR_END)) begin
            state_q <= pts_pkg::ST_IDLE;
            thr_res_q <= {1'b1, 4'h0, thr_ch_q, thr_qty_q, 1'b0,
              3'h0, thr_up};
          end else if (cycle_event) begin
            thr_cnt_q <= thr_cnt_q + 2'h1;
            if (thr_cnt_q == pts_pkg::THR_LAST_CYCLE) begin
              if (thr_val_q == thr_min) begin
                state_q <= pts_pkg::ST_IDLE;
                thr_res_q <= {1'b1, 4'h0, thr_ch_q, thr_qty_q, 1'b1,
                  3'h0, thr_val_q};
              end else begin
                thr_val_q <= thr_val_q - 5'h01;
              end
            end
          end
        end
        pts_pkg::ST_PR: begin
          if (go_idle) begin
            state_q <= pts_pkg::ST_IDLE;
          end else if (pr_done) begin
            state_q <= pts_pkg::ST_IDLE;
            pr_res_q <= {{1'b0, r_lv_amp} + {1'b0, r_rv_amp}, p_amp};
          end
        end
        pts_pkg::ST_IMP: begin
          if (go_idle) begin
            state_q <= pts_pkg::ST_IDLE;
          end else if (imp_done) begin
            state_q <= pts_pkg::ST_IDLE;
            imp_res_q <= imp_value;
          end
        end
        default: state_q <= pts_pkg::ST_IDLE;
      endcase
    end
  end

  // Settings handed to the pacing engine
  always_comb begin
    pace_d = perm_q;
    case (state_q)
      pts_pkg::ST_TEMP: pace_d = temp_q;
      pts_pkg::ST_THRESH: begin
        case ({thr_ch_q, thr_qty_q})
          2'b00: pace_d.amp_a = thr_val_q;
          2'b01: pace_d.pw_a = thr_val_q;
          2'b10: pace_d.amp_v = thr_val_q;
          default: pace_d.pw_v = thr_val_q;
        endcase
      end
      pts_pkg::ST_IMP: begin
        pace_d.amp_a = pts_pkg::AMP_5V0_IDX;
        pace_d.amp_v = pts_pkg::AMP_5V0_IDX;
        pace_d.pw_a = pts_pkg::PW_0M5_IDX;
        pace_d.pw_v = pts_pkg::PW_0M5_IDX;
      end
      default: ;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pace_set <= pts_pkg::NOMINAL_SET;
      pace_enable <= 1'b1;
      backup_vvi_en <= 1'b1;
      triggered_mode <= 1'b0;
      v_leads_joint <= 1'b0;
      temp_active <= 1'b0;
    end else begin
      pace_set <= pace_d;
      pace_enable <= (pace_d.amp_a != pts_pkg::AMP_OFF_IDX) ||
        (pace_d.amp_v != pts_pkg::AMP_OFF_IDX);
      backup_vvi_en <= (state_q != pts_pkg::ST_THRESH);
      triggered_mode <= (state_q == pts_pkg::ST_IMP);
      // Both ventricular leads driven together give the parallel value
      v_leads_joint <= (state_q == pts_pkg::ST_IMP);
      temp_active <= (state_q == pts_pkg::ST_TEMP);
    end
  end

  // Therapy requests pass on as one-cycle pulses in any state
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      emergency_req <= 1'b0;
      therapy_abort_req <= 1'b0;
    end else begin
      emergency_req <= cmd_wr && cmd == pts_pkg::CMD_EMERGENCY;
      therapy_abort_req <= cmd_wr && cmd == pts_pkg::CMD_THERAPY_ABORT;
    end
  end

endmodule : pacing_test_sequencer

// ===== pts_props.sv
// Purpose: Port checks of the pacing test sequencer
// Assumes: One hclk domain, async active-low reset
// Notes: Margins allow for the pin synchronisers
`timescale 1ns/10ps
module pts_props #(
  parameter int LINK_LOSS_CYCLES = pts_pkg::LINK_LOSS_CYCLES
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic link_present,
  input wire logic tachy_episode,
  input wire pts_pkg::pace_set_s pace_set,
  input wire logic pace_enable,
  input wire logic backup_vvi_en,
  input wire logic triggered_mode,
  input wire logic v_leads_joint,
  input wire logic temp_active,
  input wire logic busy_refusal_indication,
  input wire logic emergency_req,
  input wire logic therapy_abort_req
);
  int loss_q;
  logic [3:0] tachy_q;
  logic quiet;
  assign quiet = !temp_active && backup_vvi_en && !triggered_mode;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) loss_q <= 0;
    else if (link_present) loss_q <= 0;
    else if (loss_q <= LINK_LOSS_CYCLES + 10) loss_q <= loss_q + 1;
  end
  // Saturates so a long episode never wraps back to looking calm
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) tachy_q <= 4'h0;
    else if (!tachy_episode) tachy_q <= 4'h0;
    else if (tachy_q != 4'hF) tachy_q <= tachy_q + 4'h1;
  end
  default clocking dc @(posedge hclk); endclocking
  default disable iff (!hresetn);
  pace_off_a: assert property (
    (temp_active && pace_set.amp_a == pts_pkg::AMP_OFF_IDX &&
     pace_set.amp_v == pts_pkg::AMP_OFF_IDX) |-> !pace_enable)
    else $error("pacing allowed with amplitude off");
  step_one_a: assert property (
    (!backup_vvi_en && !$past(backup_vvi_en) && $changed(pace_set)) |->
    ((20'($past(pace_set)) - 20'(pace_set)) inside
     {20'h00001, 20'h00020, 20'h00400, 20'h08000}))
    else $error("threshold step not one field down by one");
  imp_mode_a: assert property (
    triggered_mode |-> v_leads_joint &&
    pace_set.amp_v == pts_pkg::AMP_5V0_IDX &&
    pace_set.pw_v == pts_pkg::PW_0M5_IDX)
    else $error("impedance pacing settings wrong");
  tachy_temp_a: assert property (
    $rose(temp_active) |-> tachy_q < 4'h8)
    else $error("temporary pacing started in tachy");
  tachy_test_a: assert property (
    ($fell(backup_vvi_en) || $rose(triggered_mode)) |-> tachy_q < 4'h8)
    else $error("test started in tachy");
  busy_cause_a: assert property (
    $rose(busy_refusal_indication) |-> tachy_q >= 4'h3)
    else $error("busy raised without tachy");
  link_end_a: assert property (
    (loss_q > LINK_LOSS_CYCLES + 10) |-> !temp_active && backup_vvi_en)
    else $error("session kept after link loss");
  emerg_end_a: assert property (
    emergency_req |-> ##[1:3] quiet)
    else $error("emergency left a session running");
  abort_end_a: assert property (
    therapy_abort_req |-> ##[1:3] quiet)
    else $error("abort left a session running");
endmodule : pts_props

// ===== wand_model.sv
// Purpose: Telemetry wand model driving link presence
// Assumes: Link settles a few cycles after entering range
// Notes: Leaving range drops the link at once
`timescale 1ns/10ps
module wand_model #(
  parameter int SETTLE = 3
) (
  input wire logic hclk,
  input wire logic in_range,
  output logic link_present
);
  int cnt_q = 0;
  always_ff @(posedge hclk) begin
    if (!in_range) cnt_q <= 0;
    else if (cnt_q < SETTLE) cnt_q <= cnt_q + 1;
  end
  assign link_present = in_range && (cnt_q >= SETTLE);
endmodule : wand_model

// ===== tb.sv
// Purpose: Self-checking bench for the pacing test sequencer
// Assumes: Zero-wait bus slave, shortened link loss count
// Notes: Expected values are worked out here from the setting tables
`timescale 1ns/10ps
module tb;
  localparam int LOSS = 50;
  logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic in_range = 1'b1, tachy = 1'b0, cyc = 1'b0;
  logic pr_done = 1'b0, imp_done = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, r = 32'h0;
  logic [31:0] seed = 32'h62674D5B;
  logic [31:0] hrdata, rd;
  logic hreadyout, hresp, link_present, pen, bvvi, trig, joint, tact, busy;
  logic emg, abt;
  int n_emg = 0, n_abt = 0;
  pts_pkg::pace_set_s ps, tmp_s, perm_s;
  int n_mismatch = 0, checks_done = 0, k;
  int codes[3] = '{2, 6, 9};
  always #5 hclk = ~hclk;
  wand_model u_wand (.hclk(hclk), .in_range(in_range),
    .link_present(link_present));
  pacing_test_sequencer #(.LINK_LOSS_CYCLES(LOSS)) u_dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .link_present(link_present), .tachy_episode(tachy),
    .cycle_event(cyc), .pr_done(pr_done), .p_amp(r[7:0]),
    .r_lv_amp(r[15:8]), .r_rv_amp(r[23:16]), .imp_done(imp_done),
    .imp_value(r[31:16]), .pace_set(ps), .pace_enable(pen),
    .backup_vvi_en(bvvi), .triggered_mode(trig), .v_leads_joint(joint),
    .temp_active(tact), .busy_refusal_indication(busy),
    .emergency_req(emg), .therapy_abort_req(abt));
  // One-cycle request pulses are counted away from the launching edge
  always @(negedge hclk) begin
    if (emg === 1'b1) n_emg++;
    if (abt === 1'b1) n_abt++;
  end
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  function automatic logic [31:0] pk(input pts_pkg::pace_set_s s);
    return {3'h0, s.pw_v, 3'h0, s.pw_a, 3'h0, s.amp_v, 3'h0, s.amp_a};
  endfunction : pk
  task automatic conclude();
    $display("mismatches %0d checks %0d", n_mismatch, checks_done);
    if (n_mismatch == 0 && checks_done > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : conclude
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic rdy();
    int n;
    n = 0;
    @(posedge hclk);
    while (hreadyout !== 1'b1) begin
      n++;
      if (n > 50) begin
        n_mismatch++;
        conclude();
      end
      @(posedge hclk);
    end
  endtask : rdy
  task automatic ahb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    hwrite <= w;
    htrans <= 2'h2;
    rdy();
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    rdy();
    rd = hrdata;
  endtask : ahb
  // Two extra edges let the registered pacing outputs follow the state
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    ahb(1'b1, a, d);
    repeat (2) @(posedge hclk);
    #1;
  endtask : wr
  task automatic beat(input int w);
    @(posedge hclk);
    cyc <= (w == 0);
    pr_done <= (w == 1);
    imp_done <= (w == 2);
    @(posedge hclk);
    {cyc, pr_done, imp_done} <= 3'h0;
    repeat (2) @(posedge hclk);
    #1;
  endtask : beat
  initial begin
    repeat (100000) @(posedge hclk);
    n_mismatch++;
    conclude();
  end
  initial begin
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    #1;
    chk(ps, pts_pkg::NOMINAL_SET);
    chk({pen, bvvi, tact, hreadyout, hresp}, 5'b11010);
    ahb(1'b0, 8'h40, 32'h0);
    chk(rd, 32'h0);
    r = rnd();
    perm_s = r[19:0];
    {perm_s.amp_a, perm_s.amp_v} = r[29:20] | 10'h021;
    wr(pts_pkg::ADDR_PERM, pk(perm_s));
    for (k = 3; k <= 5; k++) begin
      r = rnd();
      tmp_s = r[19:0];
      {tmp_s.amp_a, tmp_s.amp_v} = (k == 3) ? 10'h0 : (r[29:20] | 10'h021);
      wr(pts_pkg::ADDR_TEMP, pk(tmp_s));
      wr(pts_pkg::ADDR_CMD, 32'h2);
      chk(ps, tmp_s);
      chk({tact, pen}, {1'b1, k != 3});
      wr(pts_pkg::ADDR_CMD, 32'h9);
      ahb(1'b0, pts_pkg::ADDR_STATUS, 32'h0);
      chk({rd[5], tact, trig}, 3'b110);
      wr(pts_pkg::ADDR_STATUS, 32'h20);
      wr(pts_pkg::ADDR_CMD, 32'(k));
      chk(tact, 1'b0);
      if (k == 3) chk(ps, perm_s);
    end
    chk(n_emg, 32'h1);
    chk(n_abt, 32'h1);
    wr(pts_pkg::ADDR_CMD, 32'h2);
    in_range <= 1'b0;
    repeat (LOSS - 4) @(posedge hclk);
    #1;
    chk(tact, 1'b1);
    k = 0;
    while (tact !== 1'b0 && k < 60) begin
      @(posedge hclk);
      k++;
    end
    #1;
    chk({tact, ps}, {1'b0, perm_s});
    if (k >= 60) begin
      n_mismatch++;
      conclude();
    end
    // Stay out of range past the margin so the link-loss property is armed
    repeat (8) @(posedge hclk);
    in_range <= 1'b1;
    repeat (12) @(posedge hclk);
    wr(pts_pkg::ADDR_THR_CFG, 32'h0302);
    wr(pts_pkg::ADDR_CMD, 32'h6);
    for (k = 3; k >= 1; k--) begin
      chk(bvvi, 1'b0);
      chk({ps.amp_a, ps.amp_v}, {perm_s.amp_a, 5'(k)});
      repeat (4) beat(0);
    end
    chk({bvvi, ps}, {1'b1, perm_s});
    ahb(1'b0, pts_pkg::ADDR_THR_RES, 32'h0);
    chk(rd[15:0], 16'h8501);
    wr(pts_pkg::ADDR_THR_CFG, 32'h0701);
    wr(pts_pkg::ADDR_CMD, 32'h6);
    repeat (4) beat(0);
    chk({ps.pw_a, ps.pw_v}, {5'h06, perm_s.pw_v});
    repeat (3) beat(0);
    wr(pts_pkg::ADDR_CMD, 32'h7);
    chk(ps, perm_s);
    wr(pts_pkg::ADDR_CMD, 32'h1);
    ahb(1'b0, pts_pkg::ADDR_TEMP, 32'h0);
    chk(rd, pk(pts_pkg::NOMINAL_SET));
    ahb(1'b0, pts_pkg::ADDR_THR_CFG, 32'h0);
    chk(rd[12:8], 5'h0A);
    ahb(1'b0, pts_pkg::ADDR_THR_RES, 32'h0);
    chk(rd[15:0], 16'h8207);
    r = rnd();
    wr(pts_pkg::ADDR_CMD, 32'h8);
    beat(1);
    ahb(1'b0, pts_pkg::ADDR_PR_RES, 32'h0);
    chk(rd[16:0], {9'(r[15:8]) + 9'(r[23:16]), r[7:0]});
    wr(pts_pkg::ADDR_CMD, 32'h9);
    chk({trig, joint}, 2'b11);
    chk(ps.amp_v, pts_pkg::AMP_5V0_IDX);
    chk(ps.pw_v, pts_pkg::PW_0M5_IDX);
    beat(2);
    chk(trig, 1'b0);
    ahb(1'b0, pts_pkg::ADDR_IMP_RES, 32'h0);
    chk(rd[15:0], r[31:16]);
    tachy <= 1'b1;
    repeat (10) @(posedge hclk);
    foreach (codes[i]) begin
      wr(pts_pkg::ADDR_STATUS, 32'h10);
      chk(busy, 1'b0);
      wr(pts_pkg::ADDR_CMD, 32'(codes[i]));
      chk({busy, tact, bvvi, trig}, 4'b1010);
    end
    conclude();
  end
endmodule : tb
bind pacing_test_sequencer pts_props #(
  .LINK_LOSS_CYCLES(LINK_LOSS_CYCLES)
) u_props (
  .hclk(hclk), .hresetn(hresetn), .link_present(link_present),
  .tachy_episode(tachy_episode), .pace_set(pace_set),
  .pace_enable(pace_enable), .backup_vvi_en(backup_vvi_en),
  .triggered_mode(triggered_mode), .v_leads_joint(v_leads_joint),
  .temp_active(temp_active),
  .busy_refusal_indication(busy_refusal_indication),
  .emergency_req(emergency_req), .therapy_abort_req(therapy_abort_req));
